/* File: slew_pkg.sv */
// Purpose: constants and carriers for the converter transition and
//          linear regulator setpoint register bank
// Assumes: 20 MHz clock, byte-wide register port
// Notes:   step counts derived from printed step times
package slew_pkg;

  localparam int unsigned CLK_HZ = 20000000;

  // register offsets
  localparam logic [7:0] OFS_TRANSITION_CTRL = 8'h11;
  localparam logic [7:0] OFS_LINEAR_ONE      = 8'h12;
  localparam logic [7:0] OFS_LINEAR_TWO      = 8'h13;
  localparam logic [7:0] OFS_CONV_C_SETPOINT = 8'h14;

  // reset values
  localparam logic [7:0] RST_TRANSITION_CTRL = 8'h06;
  localparam logic [7:0] RST_LINEAR_ONE      = 8'h09;
  localparam logic [7:0] RST_LINEAR_TWO      = 8'h38;
  localparam logic [7:0] RST_CONV_C_SETPOINT = 8'h08;

  // transition control field positions
  localparam int unsigned BIT_GO       = 7;
  localparam int unsigned BIT_BYPASS   = 6;
  localparam int unsigned BIT_FIXED_A  = 5;
  localparam int unsigned BIT_FIXED_B  = 4;
  localparam int unsigned BIT_FIXED_C  = 3;
  localparam int unsigned SLEW_MSB     = 2;

  // linear regulator one: code in low nibble, upper nibble reserved
  localparam logic [7:0] MASK_LINEAR_ONE = 8'h0f;
  // linear regulator two: bit 7 reserved
  localparam logic [7:0] MASK_LINEAR_TWO = 8'h7f;
  // converter c setpoint: bit 6 reserved
  localparam logic [7:0] MASK_CONV_C     = 8'hbf;

  localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;

  // shortest step 3.5 us, in tenths of a microsecond
  localparam int unsigned STEP_MIN_TENTH_US = 35;
  localparam int unsigned STEP_MIN_CYC =
    (STEP_MIN_TENTH_US * (CLK_HZ / 100000)) / 100;
  localparam int unsigned STEP_MAX_CYC = STEP_MIN_CYC * 64;
  localparam int unsigned STEP_CNT_W = 13;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;

  typedef struct packed {
    logic       fixed_a;
    logic       fixed_b;
    logic       fixed_c;
    logic [3:0] linear_one_code;
    logic [6:0] linear_two_field;
    logic [5:0] conv_c_code;
    logic       conv_c_external_adjust;
  } ctrl_out_type;

endpackage

/* File: step_timer.sv */
// Purpose: per-step interval timer for stepped transitions
// Assumes: start pulse reloads, tick pulses once per interval
// Notes:   interval = shortest step shifted by (6 - code)
`timescale 1ns/10ps
module step_timer (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       start,
  input  wire logic       run,
  input  wire logic [2:0] slew,
  // event
  output logic            tick
);

  typedef struct packed {
    logic [12:0] count;
    logic        tick;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic [12:0] interval;

  always_comb begin
    // code 000b is the longest step, each code up to 110b halves it
    interval = 13'(slew_pkg::STEP_MIN_CYC << (3'd6 - slew));
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (start || !run) begin
      state_next.count = interval - 13'h0001;
    end else if (state_reg.count == 13'h0000) begin
      state_next.tick = 1'b1;
      state_next.count = interval - 13'h0001;
    end else begin
      state_next.count = state_reg.count - 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;

endmodule // step_timer

/* File: transition_regs.sv */
// Purpose: transition control and linear regulator setpoint registers
// Assumes: byte register port, unlock level from the password logic
// Notes:   one stepping engine drives only the converter c setpoint
`timescale 1ns/10ps

module transition_regs (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register port
  input  wire slew_pkg::reg_req_type req,
  input  wire logic                  unlocked,
  output logic [7:0]                 rdata,
  output logic                       rvalid,
  // converter c setpoint pins
  output logic [5:0]                 conv_c_effective_code,
  output logic                       transition_busy,
  // regulator controls
  output slew_pkg::ctrl_out_type     ctrl
);

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    STEP = 2'b01
  } phase_type;

  typedef struct packed {
    phase_type  phase;
    logic [7:0] transition_ctrl;
    logic [7:0] linear_one;
    logic [7:0] linear_two;
    logic [7:0] conv_c;
    logic [5:0] effective;
    logic [7:0] rdata;
    logic       rvalid;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic      tick;
  logic      timer_start;
  logic      wr_ok;
  logic      go_write;
  logic      setpoint_write;
  logic      start_move;
  logic [5:0] target;
  logic [2:0] slew;

  assign slew   = state_reg.transition_ctrl[slew_pkg::SLEW_MSB:0];
  assign target = state_reg.conv_c[5:0];

  step_timer u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (timer_start),
    .run   (state_reg.phase == STEP),
    .slew  (slew),
    .tick  (tick)
  );

  always_comb begin
    state_next = state_reg;
    wr_ok = req.wr && unlocked;
    go_write = wr_ok && req.addr == slew_pkg::OFS_TRANSITION_CTRL
               && req.wdata[slew_pkg::BIT_GO];
    setpoint_write = wr_ok && req.addr == slew_pkg::OFS_CONV_C_SETPOINT;
    // bypass lets a setpoint write start the move on its own
    start_move = go_write || (setpoint_write
                 && state_reg.transition_ctrl[slew_pkg::BIT_BYPASS]);
    timer_start = 1'b0;

    // register writes
    if (wr_ok) begin
      unique case (req.addr)
        slew_pkg::OFS_TRANSITION_CTRL: begin
          // go write of zero keeps a running go bit
          state_next.transition_ctrl = {
            state_reg.transition_ctrl[slew_pkg::BIT_GO]
              | req.wdata[slew_pkg::BIT_GO],
            req.wdata[slew_pkg::BIT_BYPASS:0]};
        end
        slew_pkg::OFS_LINEAR_ONE: begin
          state_next.linear_one =
            req.wdata & slew_pkg::MASK_LINEAR_ONE;
        end
        slew_pkg::OFS_LINEAR_TWO: begin
          state_next.linear_two = req.wdata & slew_pkg::MASK_LINEAR_TWO;
        end
        slew_pkg::OFS_CONV_C_SETPOINT: begin
          state_next.conv_c = req.wdata & slew_pkg::MASK_CONV_C;
        end
        default: begin
        end
      endcase
    end

    // stepping engine; new target read from the register copy each step
    unique case (state_reg.phase)
      IDLE: begin
        if (start_move) begin
          state_next.phase = STEP;
          timer_start = 1'b1;
          state_next.transition_ctrl[slew_pkg::BIT_GO] = 1'b1;
        end
      end
      STEP: begin
        if (slew == slew_pkg::SLEW_IMMEDIATE) begin
          state_next.effective = target;
        end else if (tick && state_reg.effective < target) begin
          state_next.effective = state_reg.effective + 6'h01;
        end else if (tick && state_reg.effective > target) begin
          state_next.effective = state_reg.effective - 6'h01;
        end
        // finishing wins unless a fresh start lands in the same cycle
        if (state_next.effective == target && !start_move) begin
          state_next.phase = IDLE;
          state_next.transition_ctrl[slew_pkg::BIT_GO] = 1'b0;
        end else if (start_move) begin
          state_next.transition_ctrl[slew_pkg::BIT_GO] = 1'b1;
        end
      end
      default: begin
        state_next.phase = IDLE;
      end
    endcase

    // read port, registered answer held until the next read
    state_next.rvalid = req.rd;
    if (req.rd) begin
      unique case (req.addr)
        slew_pkg::OFS_TRANSITION_CTRL: begin
          state_next.rdata = state_reg.transition_ctrl;
        end
        slew_pkg::OFS_LINEAR_ONE: begin
          state_next.rdata = state_reg.linear_one;
        end
        slew_pkg::OFS_LINEAR_TWO: begin
          state_next.rdata = state_reg.linear_two;
        end
        slew_pkg::OFS_CONV_C_SETPOINT: begin
          state_next.rdata = state_reg.conv_c;
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.phase           <= IDLE;
      state_reg.transition_ctrl <= slew_pkg::RST_TRANSITION_CTRL;
      state_reg.linear_one      <= slew_pkg::RST_LINEAR_ONE;
      state_reg.linear_two      <= slew_pkg::RST_LINEAR_TWO;
      state_reg.conv_c          <= slew_pkg::RST_CONV_C_SETPOINT;
      state_reg.effective       <= slew_pkg::RST_CONV_C_SETPOINT[5:0];
      state_reg.rdata           <= 8'h00;
      state_reg.rvalid          <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata                 = state_reg.rdata;
  assign rvalid                = state_reg.rvalid;
  assign conv_c_effective_code = state_reg.effective;
  assign transition_busy       = state_reg.transition_ctrl[slew_pkg::BIT_GO];
  assign ctrl.fixed_a =
    state_reg.transition_ctrl[slew_pkg::BIT_FIXED_A];
  assign ctrl.fixed_b =
    state_reg.transition_ctrl[slew_pkg::BIT_FIXED_B];
  assign ctrl.fixed_c =
    state_reg.transition_ctrl[slew_pkg::BIT_FIXED_C];
  assign ctrl.linear_one_code  = state_reg.linear_one[3:0];
  assign ctrl.linear_two_field = state_reg.linear_two[6:0];
  assign ctrl.conv_c_code      = state_reg.conv_c[5:0];
  assign ctrl.conv_c_external_adjust = state_reg.conv_c[7];

endmodule // transition_regs

/* File: transition_regs_asserts.sv */
// Purpose: port checker for the transition and setpoint registers
// Assumes: one clock, synchronous active low reset
// Notes:   sees top module ports only
`timescale 1ns/10ps
module transition_regs_asserts (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // register port
  input wire slew_pkg::reg_req_type  req,
  input wire logic                   unlocked,
  input wire logic [7:0]             rdata,
  input wire logic                   rvalid,
  // regulator side
  input wire logic [5:0]             conv_c_effective_code,
  input wire logic                   transition_busy,
  input wire slew_pkg::ctrl_out_type ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wr_ok;
  logic [2:0] slew_seen;
  assign wr_ok = req.wr && unlocked;

  // shadow of the step field, so immediate jumps are told from steps
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slew_seen <= slew_pkg::RST_TRANSITION_CTRL[slew_pkg::SLEW_MSB:0];
    end else if (wr_ok && req.addr == slew_pkg::OFS_TRANSITION_CTRL) begin
      slew_seen <= req.wdata[slew_pkg::SLEW_MSB:0];
    end
  end

  AST_READ_ANSWERED: assert property (req.rd |=> rvalid)
    else $error("read not answered");
  AST_RESERVED_ZERO: assert property (
    req.rd && req.addr == slew_pkg::OFS_LINEAR_ONE |=> rdata[7:4] == 4'h0)
    else $error("reserved bits not zero");
  AST_LOCKED_HOLD: assert property (
    req.wr && !unlocked |=> $stable(ctrl))
    else $error("locked write took effect");
  AST_LINEAR_CODE: assert property (
    wr_ok && req.addr == slew_pkg::OFS_LINEAR_ONE
    |=> ctrl.linear_one_code == $past(req.wdata[3:0]))
    else $error("linear code not stored");
  AST_FIXED_BITS: assert property (
    wr_ok && req.addr == slew_pkg::OFS_TRANSITION_CTRL
    |=> {ctrl.fixed_a, ctrl.fixed_b, ctrl.fixed_c} == $past(req.wdata[5:3]))
    else $error("mode bits not stored");
  AST_GO_STARTS: assert property (
    wr_ok && req.addr == slew_pkg::OFS_TRANSITION_CTRL && req.wdata[7]
    |=> transition_busy)
    else $error("trigger did not start");
  AST_DONE_AT_TARGET: assert property (
    $fell(transition_busy) |-> conv_c_effective_code == ctrl.conv_c_code)
    else $error("busy fell away from target");
  AST_STEP_PACE: assert property (
    $changed(conv_c_effective_code)
    && slew_seen != slew_pkg::SLEW_IMMEDIATE
    |=> $stable(conv_c_effective_code)[*8])
    else $error("code stepped too fast");
  AST_ONE_CODE: assert property (
    $changed(conv_c_effective_code)
    && slew_seen != slew_pkg::SLEW_IMMEDIATE
    |-> conv_c_effective_code == $past(conv_c_effective_code) + 6'h01
        || conv_c_effective_code == $past(conv_c_effective_code) - 6'h01)
    else $error("timed move jumped more than one code");
endmodule // transition_regs_asserts

bind transition_regs transition_regs_asserts chk (
  .clk, .rst_n, .req, .unlocked, .rdata, .rvalid,
  .conv_c_effective_code, .transition_busy, .ctrl);

/* File: reg_host.sv */
// Purpose: host model driving the byte register port
// Assumes: requests launched just after a rising edge
// Notes:   released write data is inverted, never left stale
`timescale 1ns/10ps
module reg_host (
  // clock
  input wire logic              clk,
  // register port
  output slew_pkg::reg_req_type req,
  input wire logic [7:0]        rdata,
  input wire logic              rvalid
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr    <= 1'b0;
    req.wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    // missing answer turns into a mismatch
    d = rvalid ? rdata : ~rdata;
  endtask
endmodule // reg_host

/* File: buck_slew_and_ldo_setpoint_regs_bench.sv */
// Purpose: self-checking bench for the transition register bank
// Assumes: 20 MHz clock, unlock level driven here
// Notes:   table of plain accesses, then transition cases
`timescale 1ns/10ps
`define CHK(a, e) begin \
  compares++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, e); \
  end \
end
module buck_slew_and_ldo_setpoint_regs_bench;
  typedef struct packed {logic w; logic [7:0] a, d, e;} row_type;
  logic                   clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   unlocked = 1'b0;
  slew_pkg::reg_req_type  req;
  slew_pkg::ctrl_out_type ctrl;
  logic [7:0]             rdata;
  logic [7:0]             d;
  logic                   rvalid;
  logic                   busy;
  logic [5:0]             eff;
  int                     fail_count = 0;
  int                     compares = 0;
  int                     n;
  row_type rows [10] = '{
    '{1'b0, 8'h11, 8'h00, 8'h06}, '{1'b0, 8'h12, 8'h00, 8'h09},
    '{1'b0, 8'h13, 8'h00, 8'h38}, '{1'b0, 8'h14, 8'h00, 8'h08},
    '{1'b1, 8'h12, 8'hff, 8'h0f}, '{1'b1, 8'h12, 8'h05, 8'h05},
    '{1'b1, 8'h13, 8'hff, 8'h7f}, '{1'b1, 8'h11, 8'h38, 8'h38},
    '{1'b1, 8'h20, 8'h55, 8'h00}, '{1'b1, 8'h11, 8'h06, 8'h06}};

  always #25 clk = ~clk;

  transition_regs uut (.clk, .rst_n, .req, .unlocked, .rdata, .rvalid,
    .conv_c_effective_code(eff), .transition_busy(busy), .ctrl);
  reg_host host (.clk, .req, .rdata, .rvalid);

  task automatic wait_code(input logic [5:0] v, output int k);
    k = 0;
    while (eff !== v && k < 10000) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  task automatic wrap_up;
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n    <= 1'b1;
    unlocked <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) host.wr(rows[i].a, rows[i].d);
      host.rd(rows[i].a, d);
      `CHK(d, rows[i].e)
    end
    `CHK(ctrl, {3'h0, 4'h5, 7'h7f, 6'h08, 1'b0})
    @(posedge clk) unlocked <= 1'b0;
    host.wr(8'h12, 8'h03);
    host.rd(8'h12, d);
    `CHK(d, 8'h05)
    @(posedge clk) unlocked <= 1'b1;
    host.wr(8'h14, 8'h0b);
    repeat (100) @(posedge clk);
    `CHK(eff, 6'h08)
    host.wr(8'h11, 8'h86);
    wait_code(6'h09, n);
    `CHK(busy, 1'b1)
    wait_code(6'h0a, n);
    `CHK(n, 70)
    wait_code(6'h0b, n);
    `CHK(n, 70)
    host.rd(8'h11, d);
    `CHK(d, 8'h06)
    `CHK(busy, 1'b0)
    host.wr(8'h11, 8'h07);
    host.wr(8'h14, 8'h20);
    host.wr(8'h11, 8'h87);
    host.rd(8'h11, d);
    `CHK(eff, 6'h20)
    `CHK(d, 8'h07)
    // keep the pace check quiet between jumps
    repeat (10) @(posedge clk);
    host.wr(8'h11, 8'h47);
    host.wr(8'h14, 8'h10);
    host.rd(8'h14, d);
    `CHK(eff, 6'h10)
    `CHK(d, 8'h10)
    // bypass with a timed step field, stepping downward
    host.wr(8'h11, 8'h45);
    host.wr(8'h14, 8'h0e);
    wait_code(6'h0f, n);
    `CHK(busy, 1'b1)
    wait_code(6'h0e, n);
    `CHK(n, 140)
    `CHK(busy, 1'b0)
    // reset in the middle of a move
    host.wr(8'h14, 8'h12);
    repeat (5) @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    host.rd(8'h11, d);
    `CHK(d, 8'h06)
    `CHK(busy, 1'b0)
    `CHK(eff, 6'h08)
    wrap_up;
  end

  initial begin
    #250000;
    fail_count++;
    wrap_up;
  end
endmodule // buck_slew_and_ldo_setpoint_regs_bench
